// *** src/ecq_channel.sv ***
// One counting channel: decode, direction, index and compare hysteresis.
`timescale 1ns/1ps
`default_nettype none
module ecq_channel import ecq_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Synchronised tracks
  input wire logic trk_a,
  input wire logic trk_b,
  input wire logic trk_n,
  // Configuration
  input wire logic position_mode,
  input wire logic dither_guard_or_count_dir,
  input wire logic index_guard,
  input wire logic compare_guard,
  input wire logic [31:0] compare_value,
  // Results
  output logic [31:0] count,
  output logic index_event,
  output logic compare_event,
  output logic overflow_event
);

  typedef struct packed {
    logic prev_a;
    logic prev_b;
    logic prev_n;
    logic last_up;
    logic match_prev;
    ecq_guard_t idx;
    ecq_guard_t cmp;
    logic [31:0] count;
    logic idx_ev;
    logic cmp_ev;
    logic ovf_ev;
  } ecq_ch_state_t;

  ecq_ch_state_t state_r;
  ecq_ch_state_t state_nxt;
  logic hyst, idx_h, cmp_h, step_pos, step, up, suppress, n_rise, match;

  // A guard re-opens only after two accepted steps in one direction.
  function automatic ecq_guard_t guard_move(input ecq_guard_t g, input logic dir_up);
    ecq_guard_t o;
    o = g;
    if (g.lock) begin
      if (dir_up == g.up) begin
        o.moved = g.moved + 2'h1;
      end else begin
        o.moved = 2'h1;
        o.up = dir_up;
      end
      if (o.moved == GUARD_STEPS) begin
        o.lock = 1'b0;
        o.moved = 2'h0;
      end
    end
    return o;
  endfunction : guard_move

  always_comb begin
    state_nxt = state_r;
    hyst = position_mode & dither_guard_or_count_dir; // [R3] [R4]
    idx_h = hyst & index_guard; // [R5]
    cmp_h = hyst & compare_guard; // [R2] [R6]
    step_pos = position_mode & ((trk_a ^ state_r.prev_a) ^ (trk_b ^ state_r.prev_b));
    step = step_pos | (~position_mode & trk_a & ~state_r.prev_a);
    up = position_mode ? ~(state_r.prev_a ^ trk_b) : ~dither_guard_or_count_dir;
    suppress = hyst & step_pos & (up != state_r.last_up); // [R18]
    n_rise = trk_n & ~state_r.prev_n;
    match = state_r.count == compare_value; // [R20]
    state_nxt.prev_a = trk_a;
    state_nxt.prev_b = trk_b;
    state_nxt.prev_n = trk_n;
    state_nxt.match_prev = match;
    state_nxt.ovf_ev = 1'b0;
    if (step_pos) begin
      state_nxt.last_up = up;
    end
    if (step & ~suppress) begin
      state_nxt.count = up ? state_r.count + 32'h00000001 : state_r.count - 32'h00000001;
      state_nxt.ovf_ev = up ? &state_r.count : ~|state_r.count;
      state_nxt.idx = guard_move(state_r.idx, up); // [R19]
      state_nxt.cmp = guard_move(state_r.cmp, up); // [R1]
    end
    state_nxt.idx_ev = n_rise & ~(idx_h & state_r.idx.lock); // [R19]
    state_nxt.cmp_ev = match & ~state_r.match_prev & ~(cmp_h & state_r.cmp.lock); // [R1]
    if (state_nxt.idx_ev & idx_h) begin
      state_nxt.idx = '{lock: 1'b1, moved: 2'h0, up: state_r.idx.up};
    end
    if (state_nxt.cmp_ev & cmp_h) begin
      state_nxt.cmp = '{lock: 1'b1, moved: 2'h0, up: state_r.cmp.up};
    end
    if (~idx_h) begin
      state_nxt.idx.lock = 1'b0; // [R3]
    end
    if (~cmp_h) begin
      state_nxt.cmp.lock = 1'b0; // [R2]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign count = state_r.count;
  assign index_event = state_r.idx_ev;
  assign compare_event = state_r.cmp_ev;
  assign overflow_event = state_r.ovf_ev;

  chk_reverse_drop: assert property (@(posedge clock) disable iff (reset) // [R18]
    suppress |=> $stable(count)) else $error("reversal pulse was counted");
  chk_index_guard: assert property (@(posedge clock) disable iff (reset) // [R19]
    idx_h && state_r.idx.lock && n_rise |=> !index_event) else $error("guarded index passed");
  chk_compare_guard: assert property (@(posedge clock) disable iff (reset) // [R1]
    cmp_h && state_r.cmp.lock && match && !state_r.match_prev |=> !compare_event)
    else $error("guarded compare passed");
  chk_freq_no_guard: assert property (@(posedge clock) disable iff (reset) // [R3]
    !position_mode && n_rise |=> index_event) else $error("index guarded in frequency mode");

endmodule : ecq_channel
`default_nettype wire

// *** src/ecq_pkg.sv ***
// Constants and types shared by the encoder counter interrupt logic.
//
// Contract
// (R1) Comparator hysteresis blocks compare logic until count moves two pulses one way.
// (R2) Comparator hysteresis only works while direction hysteresis is enabled too.
// (R3) No hysteresis of any kind in frequency and pulse width mode.
// (R4) Direction hysteresis enabled by the mode hysteresis bit of the channel.
// (R5) Index hysteresis needs mode hysteresis bit plus channel index guard bit.
// (R6) Comparator hysteresis needs mode hysteresis bit plus channel compare guard bit.
// (R7) Routing bit feeds channel 0 tracks A, B, N to channel 1 counter.
// (R8) Channel 0 extra inputs 0 to 2 may trigger channel 1 captures too.
// (R9) Index pulse raises index interrupt; buffer read clears; per channel enable.
// (R10) Clear bits 0 and 8 clear index status bits 0 and 1.
// (R11) Rising extra inputs 0 and 2 of both channels raise latch status.
// (R12) Latch status cleared by alarm reset command or clear bits 1, 2, 9, 10.
// (R13) Channel 0 event status from inputs 1, 3, overflow; mask bits 0 to 2.
// (R14) Channel 0 event status cleared by clear bits 3, 4, 5.
// (R15) Channel 1 event status, mask bits 8 to 10, clear bits 11 to 13.
// (R16) Channel 0 compare: mask bit 3, status bit 3, clear bit 6.
// (R17) Channel 1 compare: mask bit 11, status bit 11, clear bit 14.
// (R18) Direction hysteresis drops the first count pulse after each reversal.
// (R19) Index hysteresis blocks index logic until count moves two pulses one way.
// (R20) Compare register matched against counter; match sets compare status.
// (R21) Writing zero to a clear bit leaves its status unchanged.
package ecq_pkg;

  // ------------------------------------------------------------------
  // Synchroniser layout of the pins
  // ------------------------------------------------------------------
  localparam int PIN_TRK0 = 0;
  localparam int PIN_TRK1 = 3;
  localparam int PIN_XIN0 = 6;
  localparam int PIN_XIN1 = 10;
  localparam int PIN_NUM = 14;

  // ------------------------------------------------------------------
  // Status bit positions
  // ------------------------------------------------------------------
  localparam int S0_IDX0 = 0;
  localparam int S0_IDX1 = 1;
  localparam int S0_LAT = 4;
  localparam int S2_IN1 = 0;
  localparam int S2_IN3 = 1;
  localparam int S2_OVF = 2;
  localparam int S2_CMP = 3;
  localparam int S2_CH1 = 8;

  // ------------------------------------------------------------------
  // Clear register bit positions
  // ------------------------------------------------------------------
  localparam int C_IDX0 = 0;
  localparam int C_LAT_A = 1;
  localparam int C_LAT_B = 2;
  localparam int C_EVT0 = 3;
  localparam int C_CMP0 = 6;
  localparam int C_IDX1 = 8;
  localparam int C_LAT_C = 9;
  localparam int C_LAT_D = 10;
  localparam int C_EVT1 = 11;
  localparam int C_CMP1 = 14;

  // ------------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------------
  localparam logic [7:0] ST0_RESET = 8'h00;
  localparam logic [15:0] ST2_RESET = 16'h0000;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [1:0] GUARD_STEPS = 2'h2;

  typedef struct packed {
    logic lock;
    logic [1:0] moved;
    logic up;
  } ecq_guard_t;

endpackage : ecq_pkg

// *** src/ecq_top.sv ***
// Two-channel encoder counter with hysteresis, track routing and interrupts.
`timescale 1ns/1ps
`default_nettype none
module ecq_top import ecq_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Encoder tracks, asynchronous pins
  input wire logic track_a_ch0,
  input wire logic track_b_ch0,
  input wire logic track_n_ch0,
  input wire logic track_a_ch1,
  input wire logic track_b_ch1,
  input wire logic track_n_ch1,
  // Extra inputs, asynchronous pins
  input wire logic extra_input_0_ch0,
  input wire logic extra_input_1_ch0,
  input wire logic extra_input_2_ch0,
  input wire logic extra_input_3_ch0,
  input wire logic extra_input_0_ch1,
  input wire logic extra_input_1_ch1,
  input wire logic extra_input_2_ch1,
  input wire logic extra_input_3_ch1,
  // Channel mode
  input wire logic position_mode_ch0,
  input wire logic position_mode_ch1,
  input wire logic dither_guard_or_count_dir_ch0,
  input wire logic dither_guard_or_count_dir_ch1,
  input wire logic index_guard_ch0,
  input wire logic index_guard_ch1,
  input wire logic compare_guard_ch0,
  input wire logic compare_guard_ch1,
  input wire logic [31:0] compare_register_ch0,
  input wire logic [31:0] compare_register_ch1,
  // Routing
  input wire logic route_tracks_to_second_channel,
  input wire logic route_extras_to_second_channel,
  // Interrupt enables
  input wire logic index_irq_enable_ch0,
  input wire logic index_irq_enable_ch1,
  input wire logic latch_irq_enable,
  input wire logic [15:0] irq_mask,
  // Clear strobes
  input wire logic clear_write,
  input wire logic [15:0] clear_data,
  input wire logic reset_alarm_bits,
  input wire logic read_index_ch0,
  input wire logic read_index_ch1,
  // Counters and buffers
  output logic [31:0] count_ch0,
  output logic [31:0] count_ch1,
  output logic [31:0] index_buffer_ch0,
  output logic [31:0] index_buffer_ch1,
  output logic [2:0] capture_trigger_ch0,
  output logic [2:0] capture_trigger_ch1,
  // Status
  output logic [7:0] status0,
  output logic [15:0] status2,
  // Interrupt requests
  output logic index_irq,
  output logic latch_irq,
  output logic event_irq_ch0,
  output logic event_irq_ch1,
  output logic compare_irq_ch0,
  output logic compare_irq_ch1
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [PIN_NUM-1:0] sync1;
    logic [PIN_NUM-1:0] sync2;
    logic [PIN_NUM-1:0] prev;
    logic [31:0] ibuf0;
    logic [31:0] ibuf1;
    logic [2:0] cap0;
    logic [2:0] cap1;
    logic [7:0] st0;
    logic [15:0] st2;
    logic irq_idx;
    logic irq_lat;
    logic irq_ev0;
    logic irq_ev1;
    logic irq_cmp0;
    logic irq_cmp1;
  } ecq_top_state_t;

  ecq_top_state_t state_r;
  ecq_top_state_t state_nxt;

  logic [PIN_NUM-1:0] pins;
  logic [PIN_NUM-1:0] rise;
  logic [2:0] trk [2];
  logic [1:0] mode, dgd, igd, cgd;
  logic [31:0] cmpv [2];
  logic [31:0] cnt [2];
  logic [1:0] idx_ev, cmp_ev, ovf_ev;
  logic [7:0] set0, clr0;
  logic [15:0] set2, clr2;
  logic [15:0] clr;

  assign pins = {extra_input_3_ch1, extra_input_2_ch1, extra_input_1_ch1, extra_input_0_ch1,
                 extra_input_3_ch0, extra_input_2_ch0, extra_input_1_ch0, extra_input_0_ch0,
                 track_n_ch1, track_b_ch1, track_a_ch1,
                 track_n_ch0, track_b_ch0, track_a_ch0};

  // Edges are taken from the second stage only; the first stage may be metastable.
  assign rise = state_r.sync2 & ~state_r.prev;

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  assign trk[0] = state_r.sync2[PIN_TRK0 +: 3];
  // Channel 1's own tracks are simply ignored while routed.
  assign trk[1] = route_tracks_to_second_channel ? state_r.sync2[PIN_TRK0 +: 3]
                                                 : state_r.sync2[PIN_TRK1 +: 3]; // [R7]
  assign mode = {position_mode_ch1, position_mode_ch0};
  assign dgd = {dither_guard_or_count_dir_ch1, dither_guard_or_count_dir_ch0};
  assign igd = {index_guard_ch1, index_guard_ch0};
  assign cgd = {compare_guard_ch1, compare_guard_ch0};
  assign cmpv[0] = compare_register_ch0;
  assign cmpv[1] = compare_register_ch1;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      ecq_channel u_ch (
        .clock(clock),
        .reset(reset),
        .trk_a(trk[g][0]),
        .trk_b(trk[g][1]),
        .trk_n(trk[g][2]),
        .position_mode(mode[g]),
        .dither_guard_or_count_dir(dgd[g]),
        .index_guard(igd[g]),
        .compare_guard(cgd[g]),
        .compare_value(cmpv[g]),
        .count(cnt[g]),
        .index_event(idx_ev[g]),
        .compare_event(cmp_ev[g]),
        .overflow_event(ovf_ev[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Clear decoding
  // ------------------------------------------------------------------
  // Only ones in the clear word act, so a zero bit leaves its flag alone.
  assign clr = clear_write ? clear_data : 16'h0000; // [R21]

  always_comb begin
    clr0 = 8'h00;
    clr0[S0_IDX0] = clr[C_IDX0] | read_index_ch0; // [R9] [R10]
    clr0[S0_IDX1] = clr[C_IDX1] | read_index_ch1; // [R9] [R10]
    clr0[S0_LAT + 0] = clr[C_LAT_A] | reset_alarm_bits; // [R12]
    clr0[S0_LAT + 1] = clr[C_LAT_B] | reset_alarm_bits; // [R12]
    clr0[S0_LAT + 2] = clr[C_LAT_C] | reset_alarm_bits; // [R12]
    clr0[S0_LAT + 3] = clr[C_LAT_D] | reset_alarm_bits; // [R12]
    clr2 = 16'h0000;
    clr2[S2_IN1 +: 3] = clr[C_EVT0 +: 3]; // [R14]
    clr2[S2_CMP] = clr[C_CMP0]; // [R16]
    clr2[S2_CH1 + S2_IN1 +: 3] = clr[C_EVT1 +: 3]; // [R15]
    clr2[S2_CH1 + S2_CMP] = clr[C_CMP1]; // [R17]
  end

  // ------------------------------------------------------------------
  // Event collection
  // ------------------------------------------------------------------
  always_comb begin
    set0 = 8'h00;
    set0[S0_IDX0] = idx_ev[0]; // [R9]
    set0[S0_IDX1] = idx_ev[1]; // [R9]
    set0[S0_LAT + 0] = rise[PIN_XIN0 + 0]; // [R11]
    set0[S0_LAT + 1] = rise[PIN_XIN0 + 2]; // [R11]
    set0[S0_LAT + 2] = rise[PIN_XIN1 + 0]; // [R11]
    set0[S0_LAT + 3] = rise[PIN_XIN1 + 2]; // [R11]
    set2 = 16'h0000;
    set2[S2_IN1] = rise[PIN_XIN0 + 1]; // [R13]
    set2[S2_IN3] = rise[PIN_XIN0 + 3]; // [R13]
    set2[S2_OVF] = ovf_ev[0]; // [R13]
    set2[S2_CMP] = cmp_ev[0]; // [R16] [R20]
    set2[S2_CH1 + S2_IN1] = rise[PIN_XIN1 + 1]; // [R15]
    set2[S2_CH1 + S2_IN3] = rise[PIN_XIN1 + 3]; // [R15]
    set2[S2_CH1 + S2_OVF] = ovf_ev[1]; // [R15]
    set2[S2_CH1 + S2_CMP] = cmp_ev[1]; // [R17] [R20]
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.sync1 = pins;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev = state_r.sync2;
    // A new event in the clearing cycle survives: set beats clear.
    state_nxt.st0 = (state_r.st0 & ~clr0) | set0;
    state_nxt.st2 = (state_r.st2 & ~clr2) | set2;
    if (idx_ev[0]) begin
      state_nxt.ibuf0 = cnt[0];
    end
    if (idx_ev[1]) begin
      state_nxt.ibuf1 = cnt[1];
    end
    state_nxt.cap0 = rise[PIN_XIN0 +: 3];
    state_nxt.cap1 = rise[PIN_XIN1 +: 3] |
                     (route_extras_to_second_channel ? rise[PIN_XIN0 +: 3] : 3'h0); // [R8]
    state_nxt.irq_idx = (state_nxt.st0[S0_IDX0] & index_irq_enable_ch0) |
                        (state_nxt.st0[S0_IDX1] & index_irq_enable_ch1); // [R9]
    state_nxt.irq_lat = latch_irq_enable & |state_nxt.st0[S0_LAT +: 4]; // [R11]
    state_nxt.irq_ev0 = |(state_nxt.st2[S2_IN1 +: 3] & irq_mask[S2_IN1 +: 3]); // [R13]
    state_nxt.irq_ev1 = |(state_nxt.st2[S2_CH1 +: 3] & irq_mask[S2_CH1 +: 3]); // [R15]
    state_nxt.irq_cmp0 = state_nxt.st2[S2_CMP] & irq_mask[S2_CMP]; // [R16]
    state_nxt.irq_cmp1 = state_nxt.st2[S2_CH1 + S2_CMP] & irq_mask[S2_CH1 + S2_CMP]; // [R17]
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= '0;
      state_r.st0 <= ST0_RESET;
      state_r.st2 <= ST2_RESET;
      state_r.ibuf0 <= COUNT_RESET;
      state_r.ibuf1 <= COUNT_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign count_ch0 = cnt[0];
  assign count_ch1 = cnt[1];
  assign index_buffer_ch0 = state_r.ibuf0;
  assign index_buffer_ch1 = state_r.ibuf1;
  assign capture_trigger_ch0 = state_r.cap0;
  assign capture_trigger_ch1 = state_r.cap1;
  assign status0 = state_r.st0;
  assign status2 = state_r.st2;
  assign index_irq = state_r.irq_idx;
  assign latch_irq = state_r.irq_lat;
  assign event_irq_ch0 = state_r.irq_ev0;
  assign event_irq_ch1 = state_r.irq_ev1;
  assign compare_irq_ch0 = state_r.irq_cmp0;
  assign compare_irq_ch1 = state_r.irq_cmp1;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_idx0_clear;
    clear_write && clear_data[C_IDX0] && !idx_ev[0];
  endsequence

  chk_index_clear: assert property (@(posedge clock) disable iff (reset) // [R10]
    s_idx0_clear |=> !status0[S0_IDX0] &&
      (!index_irq || (status0[S0_IDX1] && index_irq_enable_ch1)))
    else $error("index status not cleared");
  chk_index_read: assert property (@(posedge clock) disable iff (reset) // [R9]
    read_index_ch1 && !idx_ev[1] |=> !status0[S0_IDX1]) else $error("read left index set");
  chk_latch_set: assert property (@(posedge clock) disable iff (reset) // [R11]
    rise[PIN_XIN1 + 2] |=> status0[S0_LAT + 3] && (latch_irq == latch_irq_enable))
    else $error("latch event lost");
  chk_zero_keeps: assert property (@(posedge clock) disable iff (reset) // [R21]
    status2[S2_CMP] && !(clear_write && clear_data[C_CMP0]) |=> status2[S2_CMP])
    else $error("compare status dropped without clear");

endmodule : ecq_top
`default_nettype wire

// *** verif/ecq_encoder_model.sv ***
// Quadrature shaft encoder model driving the A, B and N tracks of one channel.
`timescale 1ns/1ps
`default_nettype none
module ecq_encoder_model (
  // Clock
  input wire logic clock,
  // Tracks
  output logic a,
  output logic b,
  output logic n
);
  logic [1:0] phase;

  initial begin
    phase = 2'h0;
    a = 1'h0;
    b = 1'h0;
    n = 1'h0;
  end

  // Up runs 00, 10, 11, 01 on A and B; each level holds long enough for the pin sync.
  task automatic step(input logic up);
    @(posedge clock);
    phase = up ? phase + 2'h1 : phase - 2'h1;
    a <= phase[0] ^ phase[1];
    b <= phase[1];
    repeat (6) @(posedge clock);
    @(negedge clock);
  endtask : step

  task automatic index_pulse();
    @(posedge clock);
    n <= 1'h1;
    repeat (4) @(posedge clock);
    n <= 1'h0;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : index_pulse
endmodule : ecq_encoder_model
`default_nettype wire

// *** verif/ecq_top_tb_top.sv ***
// Self-checking testbench for the two-channel encoder counter.
`timescale 1ns/1ps
`default_nettype none
module ecq_top_tb_top;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic a0, b0, n0, a1, b1, n1;
  logic [7:0] xin = 8'h00;
  logic [2:0] stb = 3'h0;
  logic pm0 = 1'h1, pm1 = 1'h1, dg0 = 1'h0, dg1 = 1'h0, ig0 = 1'h0, ig1 = 1'h0;
  logic cg0 = 1'h0, cg1 = 1'h0, rt = 1'h0, rx = 1'h0, ie0 = 1'h0, ie1 = 1'h0, le = 1'h0;
  logic cw = 1'h0;
  logic [15:0] mask = 16'h0000, cd = 16'h0000, s2;
  logic [31:0] cr0 = 32'h00001000, cr1 = 32'h00001000, c0, c1, ib0, ib1, x;
  logic [2:0] ct1;
  logic [7:0] s0, e8;
  logic iq_idx, iq_lat, iq_e0, iq_e1, iq_c0, iq_c1;
  int bad_count = 0, total_checks = 0;
  int lsrc[4] = '{0, 2, 4, 6};
  int lclr[4] = '{1, 2, 9, 10};
  int esrc[4] = '{1, 3, 5, 7};
  int ebit[4] = '{0, 1, 8, 9};
  int eclr[4] = '{3, 4, 11, 12};

  always #25 clock = ~clock;

  ecq_encoder_model enc0 (.clock, .a(a0), .b(b0), .n(n0));
  ecq_encoder_model enc1 (.clock, .a(a1), .b(b1), .n(n1));

  ecq_top DUT (
    .clock, .reset,
    .track_a_ch0(a0), .track_b_ch0(b0), .track_n_ch0(n0),
    .track_a_ch1(a1), .track_b_ch1(b1), .track_n_ch1(n1),
    .extra_input_0_ch0(xin[0]), .extra_input_1_ch0(xin[1]),
    .extra_input_2_ch0(xin[2]), .extra_input_3_ch0(xin[3]),
    .extra_input_0_ch1(xin[4]), .extra_input_1_ch1(xin[5]),
    .extra_input_2_ch1(xin[6]), .extra_input_3_ch1(xin[7]),
    .position_mode_ch0(pm0), .position_mode_ch1(pm1),
    .dither_guard_or_count_dir_ch0(dg0), .dither_guard_or_count_dir_ch1(dg1),
    .index_guard_ch0(ig0), .index_guard_ch1(ig1),
    .compare_guard_ch0(cg0), .compare_guard_ch1(cg1),
    .compare_register_ch0(cr0), .compare_register_ch1(cr1),
    .route_tracks_to_second_channel(rt), .route_extras_to_second_channel(rx),
    .index_irq_enable_ch0(ie0), .index_irq_enable_ch1(ie1),
    .latch_irq_enable(le), .irq_mask(mask), .clear_write(cw), .clear_data(cd),
    .reset_alarm_bits(stb[0]), .read_index_ch0(stb[1]), .read_index_ch1(stb[2]),
    .count_ch0(c0), .count_ch1(c1), .index_buffer_ch0(ib0), .index_buffer_ch1(ib1),
    .capture_trigger_ch0(), .capture_trigger_ch1(ct1),
    .status0(s0), .status2(s2), .index_irq(iq_idx), .latch_irq(iq_lat),
    .event_irq_ch0(iq_e0), .event_irq_ch1(iq_e1),
    .compare_irq_ch0(iq_c0), .compare_irq_ch1(iq_c1)
  );

  // ------------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------------
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp_flag

  // Pin pulses are held four cycles so the two-stage sync cannot miss them.
  task automatic pulse_extra(input int k);
    @(posedge clock);
    xin[k] <= 1'h1;
    repeat (4) @(posedge clock);
    xin[k] <= 1'h0;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : pulse_extra

  task automatic clr(input logic [15:0] d);
    @(posedge clock);
    cw <= 1'h1;
    cd <= d;
    @(posedge clock);
    cw <= 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : clr

  task automatic strobe(input logic [2:0] s);
    @(posedge clock);
    stb <= s;
    @(posedge clock);
    stb <= 3'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : strobe

  task automatic move(input logic up, input int k);
    repeat (k) enc0.step(up);
  endtask : move

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp_val(s0, 32'h0);
    cmp_val(s2, 32'h0);
    e8 = 8'h00;
    for (int k = 0; k < 4; k++) begin
      pulse_extra(lsrc[k]);
      e8 = e8 | (8'h10 << k);
      cmp_val(s0, e8);
    end
    cmp_flag(iq_lat, 1'h0);
    @(posedge clock);
    le <= 1'h1;
    clr(16'h0000);
    cmp_val(s0, 32'hF0);
    cmp_flag(iq_lat, 1'h1);
    for (int k = 0; k < 4; k++) begin
      clr(16'h0001 << lclr[k]);
      e8 = e8 & ~(8'h10 << k);
      cmp_val(s0, e8);
    end
    cmp_flag(iq_lat, 1'h0);
    pulse_extra(0);
    pulse_extra(6);
    strobe(3'h1);
    cmp_val(s0, 32'h0);
    x = 32'h0;
    for (int k = 0; k < 4; k++) begin
      pulse_extra(esrc[k]);
      x = x | (32'h1 << ebit[k]);
      cmp_val(s2, x);
    end
    cmp_flag(iq_e0, 1'h0);
    @(posedge clock);
    mask <= 16'h0303;
    clr(16'h0000);
    cmp_flag(iq_e0, 1'h1);
    cmp_flag(iq_e1, 1'h1);
    for (int k = 0; k < 4; k++) begin
      clr(16'h0001 << eclr[k]);
      x = x & ~(32'h1 << ebit[k]);
      cmp_val(s2, x);
    end
    cmp_flag(iq_e1, 1'h0);
    // A down step from zero and the up step back both overflow.
    move(1'h0, 1);
    cmp_val(c0, 32'hFFFFFFFF);
    cmp_val(s2, 32'h4);
    clr(16'h0020);
    cmp_val(s2, 32'h0);
    move(1'h1, 1);
    cmp_val(s2, 32'h4);
    clr(16'h0020);
    @(posedge clock);
    dg0 <= 1'h1;
    move(1'h1, 3);
    x = c0;
    move(1'h0, 3);
    cmp_val(c0, x - 32'h2);
    move(1'h1, 3);
    cmp_val(c0, x);
    @(posedge clock);
    ig0 <= 1'h1;
    ie0 <= 1'h1;
    enc0.index_pulse();
    cmp_val(s0, 32'h1);
    cmp_flag(iq_idx, 1'h1);
    cmp_val(ib0, x);
    strobe(3'h2);
    cmp_val(s0, 32'h0);
    enc0.index_pulse();
    move(1'h1, 1);
    enc0.index_pulse();
    cmp_val(s0, 32'h0);
    move(1'h1, 1);
    enc0.index_pulse();
    cmp_val(s0, 32'h1);
    clr(16'h0001);
    cmp_val(s0, 32'h0);
    cmp_flag(iq_idx, 1'h0);
    @(posedge clock);
    pm0 <= 1'h0;
    ie0 <= 1'h0;
    enc0.index_pulse();
    clr(16'h0001);
    enc0.index_pulse();
    cmp_val(s0, 32'h1);
    cmp_flag(iq_idx, 1'h0);
    @(posedge clock);
    pm0 <= 1'h1;
    ig0 <= 1'h0;
    dg0 <= 1'h0;
    ie1 <= 1'h1;
    clr(16'h0001);
    // Bring channel 0 back to phase zero so routing shows channel 1 no jump.
    move(1'h0, 1);
    @(posedge clock);
    rt <= 1'h1;
    enc1.step(1'h1);
    enc1.step(1'h1);
    cmp_val(c1, 32'h0);
    move(1'h1, 2);
    cmp_val(c1, 32'h2);
    enc0.index_pulse();
    cmp_val(s0, 32'h3);
    cmp_val(ib1, 32'h2);
    cmp_flag(iq_idx, 1'h1);
    strobe(3'h4);
    cmp_val(s0, 32'h1);
    enc0.index_pulse();
    clr(16'h0100);
    cmp_val(s0, 32'h1);
    cmp_flag(iq_idx, 1'h0);
    @(posedge clock);
    cr0 <= c0 + 32'h2;
    cr1 <= 32'h4;
    mask <= 16'h0808;
    move(1'h1, 2);
    cmp_val(s2, 32'h0808);
    cmp_flag(iq_c0, 1'h1);
    cmp_flag(iq_c1, 1'h1);
    clr(16'h4040);
    cmp_val(s2, 32'h0);
    // The capture pulse stands for one cycle, three edges after the pin rises.
    @(posedge clock);
    rx <= 1'h1;
    xin[2] <= 1'h1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    cmp_val(ct1, 32'h4);
    @(posedge clock);
    xin[2] <= 1'h0;
    tally_and_finish();
  end
endmodule : ecq_top_tb_top
`default_nettype wire
